// ### acst_pkg.sv
// package of constants and types for the accelerometer output format and self-test block
package acst_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] RATE_OFS   = 8'h2C;
	localparam logic [7:0] FORMAT_OFS = 8'h31;
	localparam logic [7:0] DATA_X_LO  = 8'h32;
	localparam logic [7:0] DATA_X_HI  = 8'h33;
	localparam logic [7:0] DATA_Y_LO  = 8'h34;
	localparam logic [7:0] DATA_Y_HI  = 8'h35;
	localparam logic [7:0] DATA_Z_LO  = 8'h36;
	localparam logic [7:0] DATA_Z_HI  = 8'h37;

	// ****************************************
	// field positions and codes
	// ****************************************
	localparam int         RATE_CODE_LSB = 0;
	localparam int         LOW_POWER_BIT = 4;
	localparam int         SELF_TEST_BIT = 7;
	localparam int         JUSTIFY_BIT   = 2;
	localparam logic [3:0] RATE_FAST_A   = 4'hE;
	localparam logic [3:0] RATE_FAST_B   = 4'hF;
	localparam logic [3:0] RATE_TOP_CODE = 4'hF;
	localparam int         LEFT_SHIFT    = 3;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RATE_RESET   = 8'h0A;
	localparam logic [7:0] FORMAT_RESET = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam int         CLK_HZ      = 50000000;
	localparam int         TOP_RATE_HZ = 3200;
	localparam int         TOP_PERIOD  = CLK_HZ / TOP_RATE_HZ;
	localparam logic [2:0] SETTLE_TAUS = 3'h4;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed
	{
		logic signed [12:0] x;
		logic signed [12:0] y;
		logic signed [12:0] z;
	} acst_axes_t;

	typedef struct packed
	{
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} acst_bus_t;

endpackage

// ### acst_ramp.sv
// self-test stimulus ramp, reaches full level within four sample periods
`timescale 1ns/1ns
module acst_ramp
	import acst_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       st_en,
	input  wire logic       tick,
	output logic [2:0]      level
);

	typedef struct packed
	{
		logic [2:0] level;
	} acst_ramp_st_t;

	acst_ramp_st_t st_reg;
	acst_ramp_st_t st_next;

	// ****************************************
	// one step per sample toward target
	// ****************************************
	always_comb
	begin
		st_next = st_reg;
		if (tick)
		begin
			if (st_en && st_reg.level != SETTLE_TAUS)
				st_next.level = st_reg.level + 3'h1; // R03
			else if (!st_en && st_reg.level != 3'h0)
				st_next.level = st_reg.level - 3'h1; // R03
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign level = st_reg.level;

	// ****************************************
	// checks
	// ****************************************
	logic [2:0] on_ticks;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			on_ticks <= 3'h0;
		else if (!st_en)
			on_ticks <= 3'h0;
		else if (tick && on_ticks != 3'h4)
			on_ticks <= on_ticks + 3'h1;
	end

	settle_on_a: assert property (@(posedge mclk) disable iff (!rst_n) // R03
		(st_en && on_ticks == 3'h4) |-> level == SETTLE_TAUS)
		else $error("self-test level not settled after four samples");

	ramp_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // R03
		(!tick) |=> $stable(level))
		else $error("ramp moved without a sample tick");

	ramp_cov: cover property (@(posedge mclk) disable iff (!rst_n)
		$rose(level == SETTLE_TAUS));

endmodule

// ### acst_core.sv
// output word formatting and self-test stimulus for a three-axis accelerometer
`timescale 1ns/1ns
// ****************************************
// Overview of operation
// R01: at the two fastest output rates the least significant bit of each output word is forced to zero.
// R02: that zero bit sits at bit 0 of the low byte when right-justified and at bit 3 when left-justified.
// R03: after self-test toggles, the output reaches its final value within four sample periods.
// R04: the host programs the rate code to 0x0A through 0x0D or 0x0F before self-test.
// R05: the host clears the low-power bit for an accurate self-test measurement.
// R06: bit 7 of the format register at 0x31 switches self-test on when set and off when clear.
// R07: the host waits about four samples after enabling self-test before collecting samples.
// R08: the host averages equal sample counts with self-test off and on, about 0.1 s worth; the host model averages 10 samples each, about 3.1 ms at code 0x0F.
// R09: the host takes on-average minus off-average per axis, 49 mg per count; the host model takes it for the z axis only.
// R10: the host judges pass or fail on the z-axis change reaching the minimum only.
// R11: the self-test bit holds its last written value until software rewrites it.
// ****************************************
module acst_core
	import acst_pkg::*;
#(
	parameter int                 BASE_CYCLES = TOP_PERIOD,
	parameter logic signed [12:0] ST_X_SHIFT  = 13'sh0010,
	parameter logic signed [12:0] ST_Y_SHIFT  = -13'sh0010,
	parameter logic signed [12:0] ST_Z_SHIFT  = 13'sh0040
)
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire acst_bus_t  bus,
	output logic [7:0]      rdata,
	input  wire acst_axes_t raw,
	output logic            sample_tick,
	output logic            self_test_on,
	output logic            low_power
);

	typedef struct packed
	{
		logic [7:0]  rate;
		logic [7:0]  format;
		logic [31:0] cnt;
		logic        tick;
		logic [15:0] x_word;
		logic [15:0] y_word;
		logic [15:0] z_word;
		logic [7:0]  rdata;
	} acst_core_st_t;

	acst_core_st_t st_reg;
	acst_core_st_t st_next;
	logic [2:0]    level;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] period_of(input logic [3:0] code);
		logic [31:0] base;
		base = 32'(BASE_CYCLES);
		return (base << (RATE_TOP_CODE - code)) - 32'h1;
	endfunction

	function automatic logic is_fast(input logic [3:0] code);
		return code == RATE_FAST_A || code == RATE_FAST_B;
	endfunction

	function automatic logic [15:0] fmt_word(input logic signed [12:0] raw_v,
		input logic signed [12:0] shift_v, input logic [2:0] lvl,
		input logic fast, input logic left);
		logic signed [15:0] prod;
		logic signed [12:0] val;
		prod = 16'(shift_v) * $signed({13'h0, lvl});
		val = raw_v + 13'(prod >>> 2);
		if (fast)
			val[0] = 1'b0; // R01
		if (left)
			return {val, 3'h0}; // R02
		return {{3{val[12]}}, val}; // R02
	endfunction

	// ****************************************
	// self-test stimulus ramp
	// ****************************************
	// ramp steps on the edge before each output sample, so that sample already carries the new level
	acst_ramp i_acst_ramp
	(
		.mclk   (mclk),
		.rst_n  (rst_n),
		.st_en  (st_next.format[SELF_TEST_BIT]),
		.tick   (st_next.tick),
		.level  (level)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic [3:0] code;
		logic       fast;
		logic       left;
		code = st_reg.rate[RATE_CODE_LSB +: 4];
		fast = is_fast(code);
		left = st_reg.format[JUSTIFY_BIT];
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == 32'h0)
		begin
			st_next.cnt = period_of(code);
			st_next.tick = 1'b1;
		end
		else
			st_next.cnt = st_reg.cnt - 32'h1;
		if (st_reg.tick)
		begin
			st_next.x_word = fmt_word(raw.x, ST_X_SHIFT, level, fast, left);
			st_next.y_word = fmt_word(raw.y, ST_Y_SHIFT, level, fast, left);
			st_next.z_word = fmt_word(raw.z, ST_Z_SHIFT, level, fast, left);
		end
		if (bus.wr)
		begin
			case (bus.addr)
				RATE_OFS:
				begin
					st_next.rate = bus.wdata;
					st_next.cnt = period_of(bus.wdata[RATE_CODE_LSB +: 4]);
				end
				FORMAT_OFS: st_next.format = bus.wdata; // R06 R11
				default: st_next.format = st_reg.format;
			endcase
		end
		st_next.rdata = 8'h00;
		if (bus.rd)
		begin
			case (bus.addr)
				RATE_OFS:   st_next.rdata = st_reg.rate;
				FORMAT_OFS: st_next.rdata = st_reg.format;
				DATA_X_LO:  st_next.rdata = st_reg.x_word[7:0];
				DATA_X_HI:  st_next.rdata = st_reg.x_word[15:8];
				DATA_Y_LO:  st_next.rdata = st_reg.y_word[7:0];
				DATA_Y_HI:  st_next.rdata = st_reg.y_word[15:8];
				DATA_Z_LO:  st_next.rdata = st_reg.z_word[7:0];
				DATA_Z_HI:  st_next.rdata = st_reg.z_word[15:8];
				default:    st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg        <= '0;
			st_reg.rate   <= RATE_RESET;
			st_reg.format <= FORMAT_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign rdata        = st_reg.rdata;
	assign sample_tick  = st_reg.tick;
	assign self_test_on = st_reg.format[SELF_TEST_BIT]; // R06
	assign low_power    = st_reg.rate[LOW_POWER_BIT];

	// ****************************************
	// checks
	// ****************************************
	wire fast_now = is_fast(st_reg.rate[3:0]);
	wire fmt_wr   = bus.wr && bus.addr == FORMAT_OFS;

	lsb_right_a: assert property (@(posedge mclk) disable iff (!rst_n) // R01
		(st_reg.tick && fast_now && !st_reg.format[JUSTIFY_BIT] && !bus.wr) |=> st_reg.z_word[0] == 1'b0)
		else $error("right-justified lsb not zero at fast rate");

	lsb_left_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		(st_reg.tick && fast_now && st_reg.format[JUSTIFY_BIT] && !bus.wr) |=> st_reg.x_word[3:0] == 4'h0)
		else $error("left-justified lsb not zero at bit 3");

	left_pad_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		(st_reg.tick && st_reg.format[JUSTIFY_BIT] && !bus.wr) |=> st_reg.y_word[2:0] == 3'h0)
		else $error("left-justified word not padded");

	st_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		fmt_wr |=> self_test_on == $past(bus.wdata[SELF_TEST_BIT]))
		else $error("self-test bit not taken from write");

	st_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		!fmt_wr |=> $stable(self_test_on))
		else $error("self-test bit changed without a write");

	rate_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(bus.rd && bus.addr == RATE_OFS) |=> rdata == $past(st_reg.rate))
		else $error("rate register read wrong");

	idle_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!bus.rd |=> rdata == 8'h00)
		else $error("read data outside read answer");

	tick_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_tick |=> !sample_tick)
		else $error("sample ticks back to back");

	lsb_xy_a: assert property (@(posedge mclk) disable iff (!rst_n) // R01
		(st_reg.tick && fast_now && !st_reg.format[JUSTIFY_BIT] && !bus.wr) |=> !st_reg.x_word[0] && !st_reg.y_word[0])
		else $error("right-justified lsb not zero on x or y");

	data_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!st_reg.tick |=> $stable(st_reg.z_word))
		else $error("output word moved between samples");

	fast_cov: cover property (@(posedge mclk) disable iff (!rst_n)
		st_reg.tick && fast_now && st_reg.format[JUSTIFY_BIT]);

	st_on_cov: cover property (@(posedge mclk) disable iff (!rst_n)
		fmt_wr && bus.wdata[SELF_TEST_BIT] ##1 self_test_on);

	data_read_cov: cover property (@(posedge mclk) disable iff (!rst_n)
		bus.rd && bus.addr == DATA_Z_HI);

	st_off_cov: cover property (@(posedge mclk) disable iff (!rst_n)
		fmt_wr && !bus.wdata[SELF_TEST_BIT] && self_test_on);

endmodule

// ### acst_host.sv
// host-side partner model: register bus master and self-test procedure
`timescale 1ns/1ns
module acst_host
	import acst_pkg::*;
#(
	parameter int ST_MIN = 32
)
(
	input  wire logic       mclk,
	input  wire logic       sample_tick,
	input  wire logic [7:0] rdata,
	output acst_bus_t       bus
);
	initial bus = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	end
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	end
	endtask

	task automatic word(input logic [7:0] a, output logic [15:0] w);
		logic [7:0] lo;
		logic [7:0] hi;
	begin
		rd(a, lo);
		rd(8'(a + 8'h01), hi);
		w = {hi, lo};
	end
	endtask

	// wait for n sample ticks, returns once the words have updated
	task automatic tick(input int n);
		int k;
	begin
		repeat (n)
		begin
			k = 0;
			while (sample_tick !== 1'b1 && k < 5000)
			begin
				@(posedge mclk);
				#1;
				k++;
			end
			@(posedge mclk);
			#1;
		end
	end
	endtask

	task automatic avg(input int n, output int a);
		logic [15:0] w;
		int          s;
	begin
		s = 0;
		repeat (n)
		begin
			tick(1);
			word(DATA_Z_LO, w);
			s += int'($signed(w));
		end
		a = s / n;
	end
	endtask

	task automatic self_test(output int zd, output logic ok);
		int off;
		int on;
	begin
		wr(RATE_OFS, 8'h0F);
		avg(10, off);
		wr(FORMAT_OFS, 8'h80);
		tick(4);
		avg(10, on);
		wr(FORMAT_OFS, 8'h00);
		zd = on - off;
		ok = (zd >= ST_MIN);
	end
	endtask
endmodule

// ### acst_core_bench.sv
// self-checking bench for the output format and self-test block
`timescale 1ns/1ns
module acst_core_bench;
	import acst_pkg::*;
	localparam logic signed [12:0] ST_Z_SHIFT_V = 13'sh0040;
	logic        mclk;
	logic        rst_n;
	acst_bus_t   bus;
	logic [7:0]  rdata;
	acst_axes_t  raw;
	logic        sample_tick;
	logic        self_test_on;
	logic        low_power;
	logic [7:0]  d;
	logic [15:0] w;
	logic [3:0]  codes [4] = '{4'hF, 4'hE, 4'hD, 4'hA};
	int          zd;
	logic        ok;
	int          n_errors = 0;
	int          check_count = 0;

	acst_core #(.BASE_CYCLES(8), .ST_Z_SHIFT(ST_Z_SHIFT_V)) i_acst_core (.mclk(mclk), .rst_n(rst_n), .bus(bus),
		.rdata(rdata),
		.raw(raw), .sample_tick(sample_tick), .self_test_on(self_test_on), .low_power(low_power));
	acst_host i_acst_host (.mclk(mclk), .sample_tick(sample_tick), .rdata(rdata), .bus(bus));

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
	begin
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask

	task automatic results;
	begin
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	function automatic logic [15:0] fmt(input logic [12:0] v, input logic [3:0] c, input logic lft);
		logic [12:0] f;
	begin
		f = v;
		if (c >= 4'hE)
			f[0] = 1'b0;
		fmt = lft ? {f, 3'h0} : {{3{f[12]}}, f};
	end
	endfunction

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial
	begin
		#200000;
		n_errors++;
		results();
	end

	initial
	begin
		rst_n = 1'b0;
		raw = '{x: 13'h0123, y: 13'h1E05, z: 13'h0101};
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		i_acst_host.rd(RATE_OFS, d);
		check("rate reset", 16'(d), 16'(RATE_RESET));
		i_acst_host.rd(FORMAT_OFS, d);
		check("format reset", 16'(d), 16'(FORMAT_RESET));
		i_acst_host.rd(8'h40, d);
		check("unmapped read", 16'(d), 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			for (int l = 0; l < 2; l++)
			begin
				i_acst_host.wr(FORMAT_OFS, {5'h00, 1'(l), 2'h0});
				i_acst_host.wr(RATE_OFS, {4'h0, codes[i]});
				i_acst_host.tick(2);
				i_acst_host.word(DATA_X_LO, w);
				check("x word", w, fmt(raw.x, codes[i], 1'(l)));
				i_acst_host.word(DATA_Y_LO, w);
				check("y word", w, fmt(raw.y, codes[i], 1'(l)));
			end
		end
		i_acst_host.wr(RATE_OFS, 8'h0F);
		i_acst_host.wr(FORMAT_OFS, 8'h80);
		check("self test on", 16'(self_test_on), 16'h0001);
		i_acst_host.tick(4);
		i_acst_host.word(DATA_Z_LO, w);
		check("z settled on", w, fmt(13'(raw.z + ST_Z_SHIFT_V), 4'hF, 1'b0));
		i_acst_host.wr(RATE_OFS, 8'h1F);
		check("low power", 16'(low_power), 16'h0001);
		i_acst_host.rd(RATE_OFS, d);
		check("rate readback", 16'(d), 16'h001F);
		i_acst_host.rd(FORMAT_OFS, d);
		check("format held", 16'(d), 16'h0080);
		check("self test held", 16'(self_test_on), 16'h0001);
		i_acst_host.wr(FORMAT_OFS, 8'h00);
		check("self test off", 16'(self_test_on), 16'h0000);
		i_acst_host.tick(4);
		i_acst_host.word(DATA_Z_LO, w);
		check("z settled off", w, fmt(raw.z, 4'hF, 1'b0));
		i_acst_host.self_test(zd, ok);
		check("z change", 16'(zd), 16'(ST_Z_SHIFT_V));
		check("judgement", 16'(ok), 16'h0001);
		check("self test cleared", 16'(self_test_on), 16'h0000);
		results();
	end
endmodule
